// File: core/mft_ctrl.sv
// Multifunction timer control: counter, capture/match, DMA protection
//
// Chosen here: the strobed register port.
module mft_ctrl
  import mft_pkg::*;
#(
  parameter logic [7:0] PSC_PRESET  = 8'h00,
  parameter bit         PARALLEL_OK = 1'b0
) (
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output      logic [7:0] reg_rdata,
  input  wire logic       trigger,
  input  wire logic       dir_hw_en,
  input  wire logic       dir_hw_up,
  input  wire logic       par_tick,
  input  wire logic [1:0] block_end,
  output      logic [1:0] dma_req,
  output      logic [1:0] irq_event,
  output      logic [1:0] irq_block,
  output      logic       irq_wrap,
  output      logic       timer_output_a,
  output      logic       timer_output_b
);

  typedef struct packed {
    logic [15:0] cnt;
    logic [7:0]  psc;
    logic [15:0] cl0;
    logic [15:0] cl1;
    logic [15:0] m0;
    logic [15:0] m1;
    logic        lcen;
    logic        ccap;
    logic        cmat;
    logic        direction_sw_select;
    logic        of0;
    logic [7:0]  mode;
    logic        global_count_enable;
    logic        pointer_swap_enable;
    logic [1:0]  tog;
    logic [1:0]  dmsk;
    logic [1:0]  bdone;
    logic [1:0]  eobq;
    logic [1:0]  pend;
    logic [1:0]  ovr;
    logic        wpend;
    logic        outa;
    logic        outb;
    logic [7:0]  rdata;
  } mft_state_t;

  localparam mft_state_t ST_RST = '{
    cnt: CNT_RST, m0: MATCH_RST, m1: MATCH_RST, global_count_enable: GLOBAL_COUNT_ENABLE_RST,
    default: '0};

  mft_state_t st_r;
  mft_state_t st_nxt;

  // Register write decode
  function automatic logic wr_at(input logic [7:0] off);
    return reg_wr && (reg_addr == off);
  endfunction

  logic run_w;
  logic par_w;
  logic tick_w;
  logic dir_w;
  logic cap0_w;
  logic cap1_w;
  logic load0_w;
  logic wrap_w;
  logic m0hit_w;
  logic m1hit_w;
  logic capev_w;
  logic ccl_w;
  logic clr_w;

  // Run, tick and direction
  assign run_w  = st_r.lcen & st_r.global_count_enable;
  assign par_w  = PARALLEL_OK & st_r.mode[B_PAR];
  assign tick_w = run_w & (par_w ? par_tick : (st_r.psc == BYTE_RST));
  assign dir_w  = dir_hw_en ? dir_hw_up : st_r.direction_sw_select;

  // Mode decode; second mode bit unused in bivalue
  assign cap0_w  = st_r.mode[B_RM0];
  assign cap1_w  = st_r.mode[B_BIV] ? st_r.mode[B_RM0]
                                    : st_r.mode[B_RM1];
  assign load0_w = ~cap0_w;

  // Events
  assign wrap_w  = tick_w & (dir_w ? (st_r.cnt == CNT_MAX)
                                   : (st_r.cnt == CNT_RST));
  assign m0hit_w = tick_w & (st_r.cnt == st_r.m0);
  assign m1hit_w = tick_w & (st_r.cnt == st_r.m1);
  assign capev_w = trigger & (cap0_w | cap1_w);
  assign ccl_w   = wr_at(ADDR_TCTL) & reg_wdata[B_CCLR];
  assign clr_w   = (st_r.ccap & capev_w)
                 | (st_r.cmat & m0hit_w)
                 | ccl_w;

  // Next-state logic
  always_comb begin
    st_nxt = st_r;
    // Software writes
    if (wr_at(ADDR_CL0_HI)) st_nxt.cl0[15:8] = reg_wdata;
    if (wr_at(ADDR_CL0_LO)) st_nxt.cl0[7:0]  = reg_wdata;
    if (wr_at(ADDR_CL1_HI)) st_nxt.cl1[15:8] = reg_wdata;
    if (wr_at(ADDR_CL1_LO)) st_nxt.cl1[7:0]  = reg_wdata;
    if (wr_at(ADDR_M0_HI))  st_nxt.m0[15:8]  = reg_wdata;
    if (wr_at(ADDR_M0_LO))  st_nxt.m0[7:0]   = reg_wdata;
    if (wr_at(ADDR_M1_HI))  st_nxt.m1[15:8]  = reg_wdata;
    if (wr_at(ADDR_M1_LO))  st_nxt.m1[7:0]   = reg_wdata;
    if (wr_at(ADDR_TCTL)) begin
      st_nxt.lcen = reg_wdata[B_LCEN];
      st_nxt.ccap = reg_wdata[B_CCAP];
      st_nxt.cmat = reg_wdata[B_CMAT];
      st_nxt.direction_sw_select  = reg_wdata[B_UDC];
    end
    if (wr_at(ADDR_TMODE)) st_nxt.mode = reg_wdata;
    if (wr_at(ADDR_DMAC)) begin
      st_nxt.pointer_swap_enable  = reg_wdata[B_POINTER_SWAP_ENABLE];
      st_nxt.tog   = reg_wdata[B_TOG+:2];
      st_nxt.dmsk  = reg_wdata[B_DMSK+:2];
      st_nxt.bdone = reg_wdata[B_BDON+:2];
      // Test write of one raises a request in swap mode
      st_nxt.eobq = st_r.eobq & reg_wdata[B_BDON+:2];
      if (st_r.pointer_swap_enable)
        st_nxt.eobq = st_nxt.eobq
                    | (reg_wdata[B_BDON+:2] & ~st_r.bdone);
    end
    if (wr_at(ADDR_FLAGS)) begin
      st_nxt.global_count_enable  = reg_wdata[B_GLOBAL_COUNT_ENABLE];
      st_nxt.pend  = st_r.pend & ~reg_wdata[B_PEND+:2];
      st_nxt.ovr   = st_r.ovr & ~reg_wdata[B_OVR+:2];
      st_nxt.wpend = st_r.wpend & ~reg_wdata[B_WPND];
    end

    // Prescaler runs with the counter
    if (run_w)
      st_nxt.psc = (st_r.psc == BYTE_RST) ? PSC_PRESET
                                          : st_r.psc - 8'h01;

    // Counting and end of count
    if (tick_w) begin
      st_nxt.cnt = dir_w ? st_r.cnt + 16'h0001
                         : st_r.cnt - 16'h0001;
      if (wrap_w) begin
        if (load0_w)
          st_nxt.cnt = st_r.cl0;
        if (st_r.mode[B_ONE])
          st_nxt.lcen = 1'b0;
      end
    end

    // Trigger captures regardless of enable; loads only when halted or with B_REN clear
    if (trigger) begin
      if (cap0_w) begin
        st_nxt.cl0 = st_r.cnt;
        st_nxt.of0 = wrap_w;
      end
      if (cap1_w)
        st_nxt.cl1 = st_r.cnt;
      if (load0_w && (!st_r.mode[B_REN] || !run_w)) begin
        st_nxt.cnt = st_r.cl0;
        st_nxt.psc = PSC_PRESET;
      end
    end

    // Clear sources take priority over counting and loads
    if (clr_w) begin
      st_nxt.cnt = CNT_RST;
      st_nxt.psc = PSC_PRESET;
    end

    // Pending and overrun; hardware set wins over clear
    if (m0hit_w) begin
      if (st_r.pend[0]) st_nxt.ovr[0] = 1'b1;
      st_nxt.pend[0] = 1'b1;
    end
    if (trigger && cap0_w) begin
      if (st_r.pend[1]) st_nxt.ovr[1] = 1'b1;
      st_nxt.pend[1] = 1'b1;
    end
    if (wrap_w) st_nxt.wpend = 1'b1;

    // Block end per channel with protection
    for (int ch = 0; ch < 2; ch++) begin
      if (block_end[ch]) begin
        if (st_r.bdone[ch])
          st_nxt.dmsk[ch] = 1'b0;
        st_nxt.bdone[ch] = 1'b1;
        st_nxt.eobq[ch]  = 1'b1;
        if (st_r.pointer_swap_enable)
          st_nxt.tog[ch] = ~st_r.tog[ch];
      end
    end

    // Output waveforms: wrap sets, matches reset
    if (wrap_w) begin
      st_nxt.outa = 1'b1;
      st_nxt.outb = 1'b1;
    end else begin
      if (m0hit_w) st_nxt.outa = 1'b0;
      if (m1hit_w) st_nxt.outb = 1'b0;
    end

    // Read data stands in the cycle after the strobe
    st_nxt.rdata = BYTE_RST;
    if (reg_rd) begin
      case (reg_addr)
        ADDR_CL0_HI: st_nxt.rdata = st_r.cl0[15:8];
        ADDR_CL0_LO: st_nxt.rdata = st_r.cl0[7:0];
        ADDR_CL1_HI: st_nxt.rdata = st_r.cl1[15:8];
        ADDR_CL1_LO: st_nxt.rdata = st_r.cl1[7:0];
        ADDR_M0_HI:  st_nxt.rdata = st_r.m0[15:8];
        ADDR_M0_LO:  st_nxt.rdata = st_r.m0[7:0];
        ADDR_M1_HI:  st_nxt.rdata = st_r.m1[15:8];
        ADDR_M1_LO:  st_nxt.rdata = st_r.m1[7:0];
        ADDR_TCTL:   st_nxt.rdata = {st_r.lcen, st_r.ccap, st_r.cmat,
                                     1'b0, st_r.direction_sw_select, dir_w, st_r.of0,
                                     run_w};
        ADDR_TMODE:  st_nxt.rdata = st_r.mode;
        ADDR_DMAC:   st_nxt.rdata = {st_r.bdone, st_r.dmsk, 1'b0,
                                     st_r.tog, st_r.pointer_swap_enable};
        ADDR_FLAGS:  st_nxt.rdata = {2'b00, st_r.wpend, st_r.ovr,
                                     st_r.pend, st_r.global_count_enable};
        default:     st_nxt.rdata = BYTE_RST;
      endcase
    end
  end

  // State register
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= ST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs
  assign reg_rdata = st_r.rdata;
  assign dma_req   = st_r.pend & st_r.dmsk;
  assign irq_event = st_r.pend & ~st_r.dmsk;
  assign irq_wrap  = st_r.wpend;
  assign irq_block = st_r.eobq & {2{~(|dma_req) & ~st_r.wpend}};
  assign timer_output_a = st_r.mode[B_OEA] ? st_r.outa : 1'b1;
  assign timer_output_b = st_r.mode[B_OEB] ? st_r.outb : 1'b1;

  // Checks
  sequence s_ccl_wr;
    reg_wr && (reg_addr == ADDR_TCTL) && reg_wdata[B_CCLR];
  endsequence

  sequence s_tctl_rd;
    reg_rd && (reg_addr == ADDR_TCTL);
  endsequence

  AST_HALT_HOLDS: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (!run_w && !trigger && !ccl_w) |=> $stable(st_r.cnt))
    else $error("counter moved while halted");

  AST_GLOBAL_COUNT_ENABLE_RST: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ($past(sys_rst) |-> st_r.global_count_enable))
    else $error("global enable not set after reset");

  AST_CCL_CLEARS: assert property (@(posedge ref_clk) disable iff (sys_rst)
    s_ccl_wr |=> (st_r.cnt == CNT_RST)
      && ($past(wrap_w) || (irq_wrap == $past(irq_wrap))))
    else $error("counter clear failed");

  AST_CCL_READ0: assert property (@(posedge ref_clk) disable iff (sys_rst)
    s_tctl_rd |=> !reg_rdata[B_CCLR])
    else $error("counter clear bit read as one");

  AST_DIR_STAT: assert property (@(posedge ref_clk) disable iff (sys_rst)
    s_tctl_rd |=> reg_rdata[2] == $past(dir_w))
    else $error("direction status wrong");

  AST_CAP_HALTED: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (trigger && cap0_w && !st_r.lcen) |=>
      st_r.cl0 == $past(st_r.cnt))
    else $error("capture lost while halted");

  AST_OUT_HIGH: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !st_r.mode[B_OEA] |-> timer_output_a)
    else $error("disabled output not high");

  AST_PROTECT: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (block_end[0] && st_r.bdone[0]) |=> !st_r.dmsk[0])
    else $error("dma mask not cleared on second block end");

  AST_OVERRUN: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (m0hit_w && st_r.pend[0]) |=> st_r.ovr[0] [*2])
    else $error("overrun not flagged");

  AST_MATCH_CLR: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (st_r.cmat && m0hit_w) |=> st_r.cnt == CNT_RST)
    else $error("clear on match failed");

  AST_BLK_HOLD: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (irq_block[0] |-> !(|dma_req) && !irq_wrap))
    else $error("block request not held off");

endmodule // mft_ctrl

// File: inc/mft_pkg.sv
// Constants for the multifunction timer control block
package mft_pkg;
  // Register offsets
  localparam logic [7:0] ADDR_CL0_HI = 8'hf0;
  localparam logic [7:0] ADDR_CL0_LO = 8'hf1;
  localparam logic [7:0] ADDR_CL1_HI = 8'hf2;
  localparam logic [7:0] ADDR_CL1_LO = 8'hf3;
  localparam logic [7:0] ADDR_M0_HI  = 8'hf4;
  localparam logic [7:0] ADDR_M0_LO  = 8'hf5;
  localparam logic [7:0] ADDR_M1_HI  = 8'hf6;
  localparam logic [7:0] ADDR_M1_LO  = 8'hf7;
  localparam logic [7:0] ADDR_TCTL   = 8'hf8;
  localparam logic [7:0] ADDR_TMODE  = 8'hf9;
  localparam logic [7:0] ADDR_DMAC   = 8'hfa;
  localparam logic [7:0] ADDR_FLAGS  = 8'hfb;
  // Timer control bits
  localparam int B_LCEN = 7;
  localparam int B_CCAP = 6;
  localparam int B_CMAT = 5;
  localparam int B_CCLR = 4;
  localparam int B_UDC  = 3;
  // Mode bits
  localparam int B_OEB  = 7;
  localparam int B_OEA  = 6;
  localparam int B_BIV  = 5;
  localparam int B_RM1  = 4;
  localparam int B_RM0  = 3;
  localparam int B_PAR  = 2;
  localparam int B_REN  = 1;
  localparam int B_ONE  = 0;
  // DMA control bits
  localparam int B_POINTER_SWAP_ENABLE = 0;
  localparam int B_TOG  = 1;
  localparam int B_DMSK = 4;
  localparam int B_BDON = 6;
  // Flag register bits
  localparam int B_GLOBAL_COUNT_ENABLE = 0;
  localparam int B_PEND = 1;
  localparam int B_OVR  = 3;
  localparam int B_WPND = 5;
  // Reset values and counter maximum
  localparam logic [15:0] CNT_RST  = 16'h0000;
  localparam logic [15:0] MATCH_RST = 16'h0000;
  localparam logic [7:0]  BYTE_RST = 8'h00;
  localparam logic        GLOBAL_COUNT_ENABLE_RST = 1'b1;
  localparam logic [15:0] CNT_MAX  = 16'hffff;
endpackage

// File: sim/mft_pin_model.sv
// Model of the timer's external input pins and DMA block-end lines
module mft_pin_model (
  input  wire logic       ref_clk,
  output      logic       trigger,
  output      logic [1:0] block_end,
  output      logic       dir_hw_en,
  output      logic       dir_hw_up
);
  timeunit 1ns;
  timeprecision 1ps;

  // Pins idle until the bench asks for an event
  initial begin
    trigger   = 1'b0;
    block_end = 2'b00;
    dir_hw_en = 1'b0;
    dir_hw_up = 1'b0;
  end

  // One-cycle trigger pulse, no edge detection is done on it
  task automatic fire_trigger();
    @(posedge ref_clk);
    trigger <= 1'b1;
    @(posedge ref_clk);
    trigger <= 1'b0;
  endtask

  // One-cycle block-end pulse on the chosen channels
  task automatic fire_block(input logic [1:0] ch);
    @(posedge ref_clk);
    block_end <= ch;
    @(posedge ref_clk);
    block_end <= 2'b00;
  endtask

  // Direction pins, levels held until changed
  task automatic set_dir(input logic en, input logic up);
    @(posedge ref_clk);
    dir_hw_en <= en;
    dir_hw_up <= up;
  endtask
endmodule // mft_pin_model

// File: sim/multifunction_timer_ctrl_bench.sv
// Self-checking bench for the timer control block
module multifunction_timer_ctrl_bench
  import mft_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk   = 1'b0;
  logic        sys_rst   = 1'b1;
  logic [7:0]  reg_addr  = 8'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic [7:0]  reg_rdata;
  logic        trigger, dir_hw_en, dir_hw_up, irq_wrap, out_a, out_b;
  logic [1:0]  block_end, dma_req, irq_event, irq_block;
  logic [15:0] v;
  logic        par_tick  = 1'b0;
  int          failures    = 0;
  int          check_count = 0;

  // 250 MHz clock
  always #2 ref_clk = ~ref_clk;

  mft_pin_model pins (.ref_clk(ref_clk), .trigger(trigger),
    .block_end(block_end), .dir_hw_en(dir_hw_en), .dir_hw_up(dir_hw_up));

  mft_ctrl dut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .trigger(trigger), .dir_hw_en(dir_hw_en),
    .dir_hw_up(dir_hw_up), .par_tick(par_tick), .block_end(block_end),
    .dma_req(dma_req), .irq_event(irq_event), .irq_block(irq_block),
    .irq_wrap(irq_wrap), .timer_output_a(out_a), .timer_output_b(out_b));

  // Compare and count
  task automatic chk(input string n, input logic [15:0] s, e);
    check_count++;
    if (s !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask

  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    // Let the registered result settle before anyone looks
    #1;
  endtask

  // Read data taken in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic rchk(input string n, input logic [7:0] a, e);
    logic [7:0] d;
    rd(a, d);
    chk(n, {8'h00, d}, {8'h00, e});
  endtask

  task automatic rd16(input logic [7:0] a, output logic [15:0] d);
    logic [7:0] h, l;
    rd(a, h);
    rd(a + 8'h01, l);
    d = {h, l};
  endtask

  task automatic set_cl0(input logic [15:0] d);
    wr(ADDR_CL0_HI, d[15:8]);
    wr(ADDR_CL0_LO, d[7:0]);
  endtask

  task automatic cap0(input logic [7:0] mode);
    wr(ADDR_TMODE, mode);
    pins.fire_trigger();
    rd16(ADDR_CL0_HI, v);
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Watchdog, far beyond the expected run of a few hundred cycles
  initial begin
    #100000;
    failures++;
    final_report();
  end

  // Test sequence
  initial begin
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    for (int a = 4; a < 10; a++) rchk("rst", 8'(8'hf0 + a), 8'h00);
    rchk("flags", ADDR_FLAGS, 8'h01);
    rchk("unmapped", 8'h10, 8'h00);
    wr(ADDR_M1_HI, 8'ha5);
    rchk("match1", ADDR_M1_HI, 8'ha5);
    chk("outs_off", {14'h0, out_b, out_a}, 16'h0003);
    wr(ADDR_TMODE, 8'hc0);
    chk("outs_on", {14'h0, out_b, out_a}, 16'h0000);
    $display("test reset done");
    // Each of the four RM1/RM0 register modes, bivalue clear, with the counter halted
    for (int m = 0; m < 4; m++) begin
      set_cl0(m[0] ? 16'h0000 : 16'h1234);
      wr(ADDR_CL1_HI, 8'h00);
      wr(ADDR_CL1_LO, 8'h00);
      cap0(8'(m << 3));
      chk("cl0", v, 16'h1234);
      rd16(ADDR_CL1_HI, v);
      chk("cl1", v, m[1] ? 16'h1234 : 16'h0000);
    end
    $display("test modes done");
    wr(ADDR_TCTL, 8'h08);
    rchk("dir_sw", ADDR_TCTL, 8'h0c);
    pins.set_dir(1'b1, 1'b0);
    rchk("dir_pin", ADDR_TCTL, 8'h08);
    pins.set_dir(1'b0, 1'b0);
    wr(ADDR_TCTL, 8'h10);
    rchk("clr_rd", ADDR_TCTL, 8'h00);
    cap0(8'h08);
    chk("clr_cnt", v, 16'h0000);
    chk("clr_irq", {15'h0, irq_wrap}, 16'h0000);
    set_cl0(16'h1234);
    wr(ADDR_TMODE, 8'h00);
    pins.fire_trigger();
    wr(ADDR_TCTL, 8'h40);
    cap0(8'h08);
    chk("ccap1", v, 16'h1234);
    cap0(8'h08);
    chk("ccap2", v, 16'h0000);
    wr(ADDR_FLAGS, 8'h00);
    wr(ADDR_TCTL, 8'h88);
    rchk("global_count_enable_off", ADDR_TCTL, 8'h8c);
    cap0(8'h08);
    chk("global_count_enable_hold", v, 16'h0000);
    wr(ADDR_FLAGS, 8'h01);
    rchk("global_count_enable_on", ADDR_TCTL, 8'h8d);
    $display("test control done");
    set_cl0(16'hfffd);
    wr(ADDR_TMODE, 8'h01);
    pins.fire_trigger();
    wr(ADDR_TCTL, 8'h88);
    repeat (10) @(posedge ref_clk);
    rchk("oneshot", ADDR_TCTL, 8'h0c);
    chk("wrap_irq", {15'h0, irq_wrap}, 16'h0001);
    cap0(8'h09);
    chk("reload", v, 16'hfffd);
    wr(ADDR_TMODE, 8'h00);
    wr(ADDR_TCTL, 8'h88);
    repeat (10) @(posedge ref_clk);
    rchk("contin", ADDR_TCTL, 8'h8d);
    $display("test run modes done");
    wr(ADDR_TCTL, 8'h18);
    wr(ADDR_FLAGS, 8'h3f);
    wr(ADDR_M0_HI, 8'h00);
    wr(ADDR_M0_LO, 8'h05);
    wr(ADDR_TCTL, 8'ha8);
    repeat (30) @(posedge ref_clk);
    wr(ADDR_TCTL, 8'h08);
    rchk("overrun", ADDR_FLAGS, 8'h0b);
    chk("ev0", {14'h0, irq_event}, 16'h0001);
    cap0(8'h08);
    chk("cmat", {15'h0, v <= 16'h0005}, 16'h0001);
    $display("test match done");
    wr(ADDR_FLAGS, 8'h3f);
    pins.fire_block(2'b01);
    rchk("bdone", ADDR_DMAC, 8'h40);
    chk("irq_blk", {14'h0, irq_block}, 16'h0001);
    wr(ADDR_DMAC, 8'h50);
    pins.fire_block(2'b01);
    rchk("protect", ADDR_DMAC, 8'h40);
    // Handler order: flag, overrun check, pending, then mask
    wr(ADDR_DMAC, 8'h00);
    rchk("no_ovr", ADDR_FLAGS, 8'h01);
    wr(ADDR_FLAGS, 8'h07);
    wr(ADDR_DMAC, 8'h10);
    chk("handled", {12'h0, dma_req, irq_block}, 16'h0000);
    wr(ADDR_DMAC, 8'h01);
    wr(ADDR_DMAC, 8'h81);
    chk("sw_blk", {14'h0, irq_block}, 16'h0002);
    pins.fire_block(2'b01);
    rchk("swap", ADDR_DMAC, 8'hc3);
    $display("test dma done");
    final_report();
  end
endmodule // multifunction_timer_ctrl_bench
